// *** hw/light_prox_defines.vh ***
// constants for the result, threshold and interrupt register block
// assumes a byte-wide register map reached over the two-wire serial bus
`ifndef LIGHT_PROX_DEFINES_VH
`define LIGHT_PROX_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_AMBIENT_RESULT_HIGH   8'h85
`define OFS_AMBIENT_RESULT_LOW    8'h86
`define OFS_PROXIMITY_RESULT_HIGH 8'h87
`define OFS_PROXIMITY_RESULT_LOW  8'h88
`define OFS_INTERRUPT_CONTROL     8'h89
`define OFS_LOW_THRESHOLD_HIGH    8'h8A
`define OFS_LOW_THRESHOLD_LOW     8'h8B
`define OFS_HIGH_THRESHOLD_HIGH   8'h8C
`define OFS_HIGH_THRESHOLD_LOW    8'h8D
`define OFS_INTERRUPT_STATUS      8'h8E

// ****************************************
// interrupt control fields
// ****************************************
`define ICTL_COUNT_MSB            7
`define ICTL_COUNT_LSB            5
`define ICTL_PROX_READY_EN        3
`define ICTL_ALS_READY_EN         2
`define ICTL_THRESHOLD_IRQ_ENABLE 1
`define ICTL_THRESHOLD_SOURCE_SEL 0

// ****************************************
// interrupt status fields
// ****************************************
`define STAT_PROX_READY           3
`define STAT_ALS_READY            2
`define STAT_BELOW_LOW            1
`define STAT_ABOVE_HIGH           0

// ****************************************
// reset values
// ****************************************
`define RST_INTERRUPT_CONTROL     8'h00
`define RST_THRESHOLD             16'h0000
`define RST_RESULT                16'h0000
`define RST_STATUS                4'h0
`define RST_BYTE                  8'h00

// ****************************************
// serial bus
// ****************************************
`define DEVICE_ADDRESS            7'h2A
`define BITS_PER_BYTE             4'h8
`define LAST_BIT                  4'h7

`endif

// *** hw/light_prox_result_threshold_irq.v ***
// result, threshold and interrupt logic behind a two-wire serial slave
// assumes scl/sda come from pins; results and valids come from logic on clk
`timescale 1ns/1ns
`include "light_prox_defines.vh"

// What this block does
// RULE1 - self-timed mode holds old control setting
// RULE2 - ambient result read-only at 85h/86h
// RULE3 - proximity result read-only at 87h/88h
// RULE4 - count code n needs 2^n measurements
// RULE5 - proximity ready interrupt when enabled
// RULE6 - ambient ready interrupt when enabled
// RULE7 - threshold interrupt outside window when enabled
// RULE8 - select 0 proximity, 1 ambient
// RULE9 - low threshold read/write at 8Ah/8Bh
// RULE10 - high threshold read/write at 8Ch/8Dh
// RULE11 - flags sticky until host writes one
// RULE12 - interrupt pin low while flag set
// RULE13 - four separate status flags
// RULE14 - in-window measurement clears consecutive count
module light_prox_result_threshold_irq #(
  parameter [6:0] device_address = `DEVICE_ADDRESS  // arbitrary value
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         int_n,
  input  wire [15:0] als_result,
  input  wire        als_valid,
  input  wire [15:0] prox_result,
  input  wire        prox_valid,
  input  wire        self_timed_on
);

  // ****************************************
  // state codes
  // ****************************************
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_ADDR  = 3'h1;
  localparam [2:0] S_REGP  = 3'h2;
  localparam [2:0] S_WDATA = 3'h3;
  localparam [2:0] S_ACK   = 3'h4;
  localparam [2:0] S_RDATA = 3'h5;
  localparam [2:0] S_MACK  = 3'h6;

  // ****************************************
  // declarations
  // ****************************************
  reg  [1:0]  scl_sync;
  reg  [1:0]  sda_sync;
  reg         scl_d;
  reg         sda_d;
  reg  [2:0]  state;
  reg  [2:0]  after_ack;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shift_in;
  reg  [7:0]  shift_out;
  reg  [7:0]  pointer;
  reg         master_ack;
  reg         wr_en;
  reg  [7:0]  wr_addr;
  reg  [7:0]  wr_data;
  reg  [15:0] als_value;
  reg  [15:0] prox_value;
  reg  [7:0]  ictl_written;
  reg  [7:0]  ictl_active;
  reg  [15:0] low_threshold;
  reg  [15:0] high_threshold;
  reg  [3:0]  status;
  reg  [7:0]  consec_cnt;
  reg  [7:0]  read_byte;
  reg  [3:0]  next_status;
  wire        scl_s      = scl_sync[1];
  wire        sda_s      = sda_sync[1];
  wire        scl_rise   = scl_s & ~scl_d;
  wire        scl_fall   = ~scl_s & scl_d;
  wire        start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire        stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  wire [7:0]  byte_in    = shift_in;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'h1;
      sda_d    <= 1'h1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_s;
      sda_d    <= sda_s;
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  always @* begin
    case (pointer)
      // RULE2 - ambient result bytes
      `OFS_AMBIENT_RESULT_HIGH:   read_byte = als_value[15:8];
      `OFS_AMBIENT_RESULT_LOW:    read_byte = als_value[7:0];
      // RULE3 - proximity result bytes
      `OFS_PROXIMITY_RESULT_HIGH: read_byte = prox_value[15:8];
      `OFS_PROXIMITY_RESULT_LOW:  read_byte = prox_value[7:0];
      `OFS_INTERRUPT_CONTROL:     read_byte = ictl_written;
      // RULE9 - low threshold readback
      `OFS_LOW_THRESHOLD_HIGH:    read_byte = low_threshold[15:8];
      `OFS_LOW_THRESHOLD_LOW:     read_byte = low_threshold[7:0];
      // RULE10 - high threshold readback
      `OFS_HIGH_THRESHOLD_HIGH:   read_byte = high_threshold[15:8];
      `OFS_HIGH_THRESHOLD_LOW:    read_byte = high_threshold[7:0];
      `OFS_INTERRUPT_STATUS:      read_byte = {4'h0, status};
      default:                    read_byte = `RST_BYTE;
    endcase
  end

  // ****************************************
  // serial slave
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      state      <= S_IDLE;
      after_ack  <= S_IDLE;
      bit_cnt    <= 4'h0;
      shift_in   <= `RST_BYTE;
      shift_out  <= `RST_BYTE;
      pointer    <= `RST_BYTE;
      master_ack <= 1'h0;
      sda_out    <= 1'h0;
      sda_oe     <= 1'h0;
      wr_en      <= 1'h0;
      wr_addr    <= `RST_BYTE;
      wr_data    <= `RST_BYTE;
    end else begin
      wr_en <= 1'h0;
      if (start_cond) begin
        state   <= S_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'h0;
      end else if (stop_cond) begin
        state  <= S_IDLE;
        sda_oe <= 1'h0;
      end else begin
        case (state)
          S_ADDR, S_REGP, S_WDATA: begin
            if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
              shift_in <= {shift_in[6:0], sda_s};
              bit_cnt  <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (state == S_ADDR) begin
                if (byte_in[7:1] == device_address) begin
                  sda_oe    <= 1'h1;
                  state     <= S_ACK;
                  after_ack <= byte_in[0] ? S_RDATA : S_REGP;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                sda_oe    <= 1'h1;
                state     <= S_ACK;
                after_ack <= S_WDATA;
                if (state == S_REGP) begin
                  pointer <= byte_in;
                end else begin
                  wr_en   <= 1'h1;
                  wr_addr <= pointer;
                  wr_data <= byte_in;
                  pointer <= pointer + 8'h01;
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              state  <= after_ack;
              sda_oe <= 1'h0;
              if (after_ack == S_RDATA) begin
                shift_out <= read_byte;
                sda_oe    <= ~read_byte[7];
                pointer   <= pointer + 8'h01;
              end
            end
          end
          S_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == `LAST_BIT) begin
                bit_cnt <= 4'h0;
                sda_oe  <= 1'h0;
                state   <= S_MACK;
              end else begin
                bit_cnt   <= bit_cnt + 4'h1;
                shift_out <= {shift_out[6:0], 1'h0};
                sda_oe    <= ~shift_out[6];
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall) begin
              if (master_ack) begin
                state     <= S_RDATA;
                shift_out <= read_byte;
                sda_oe    <= ~read_byte[7];
                pointer   <= pointer + 8'h01;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state  <= S_IDLE;
            sda_oe <= 1'h0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // registers and threshold logic
  // ****************************************
  wire        sel_als     = ictl_active[`ICTL_THRESHOLD_SOURCE_SEL];
  // RULE8 - threshold source routing
  wire        sel_valid   = sel_als ? als_valid : prox_valid;
  wire [15:0] sel_value   = sel_als ? als_result : prox_result;
  // RULE7 - window comparison
  wire        is_above    = sel_value > high_threshold;
  wire        is_below    = sel_value < low_threshold;
  wire [7:0]  consec_next = consec_cnt + 8'h01;
  // RULE4 - two to the power of code
  wire [7:0]  consec_need = 8'h01 << ictl_active[`ICTL_COUNT_MSB:`ICTL_COUNT_LSB];
  wire        count_hit   = consec_next == consec_need;
  always @* begin
    // RULE11 - write one clears
    next_status = status & ~({4{wr_en && wr_addr == `OFS_INTERRUPT_STATUS}} & wr_data[3:0]);
    // RULE5 - proximity ready flag
    next_status[`STAT_PROX_READY] = next_status[`STAT_PROX_READY] |
                                    (prox_valid & ictl_active[`ICTL_PROX_READY_EN]);
    // RULE6 - ambient ready flag
    next_status[`STAT_ALS_READY] = next_status[`STAT_ALS_READY] |
                                   (als_valid & ictl_active[`ICTL_ALS_READY_EN]);
    // RULE13 - separate threshold flags
    if (sel_valid && count_hit && ictl_active[`ICTL_THRESHOLD_IRQ_ENABLE]) begin
      next_status[`STAT_ABOVE_HIGH] = next_status[`STAT_ABOVE_HIGH] | is_above;
      next_status[`STAT_BELOW_LOW]  = next_status[`STAT_BELOW_LOW] | is_below;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      als_value      <= `RST_RESULT;
      prox_value     <= `RST_RESULT;
      ictl_written   <= `RST_INTERRUPT_CONTROL;
      ictl_active    <= `RST_INTERRUPT_CONTROL;
      low_threshold  <= `RST_THRESHOLD;
      high_threshold <= `RST_THRESHOLD;
      status         <= `RST_STATUS;
      consec_cnt     <= 8'h00;
      int_n          <= 1'h1;
    end else begin
      als_value  <= als_valid ? als_result : als_value;
      prox_value <= prox_valid ? prox_result : prox_value;
      if (wr_en) begin
        case (wr_addr)
          `OFS_INTERRUPT_CONTROL:   ictl_written          <= wr_data;
          `OFS_LOW_THRESHOLD_HIGH:  low_threshold[15:8]   <= wr_data;
          `OFS_LOW_THRESHOLD_LOW:   low_threshold[7:0]    <= wr_data;
          `OFS_HIGH_THRESHOLD_HIGH: high_threshold[15:8]  <= wr_data;
          `OFS_HIGH_THRESHOLD_LOW:  high_threshold[7:0]   <= wr_data;
          default:                  ;
        endcase
      end
      // RULE1 - take over only when stopped
      if (!self_timed_on) begin
        ictl_active <= ictl_written;
      end
      // RULE14 - in window clears count
      if (sel_valid) begin
        consec_cnt <= (!(is_above || is_below) || count_hit) ? 8'h00 : consec_next;
      end
      status <= next_status;
      // RULE12 - pin low while flagged
      int_n  <= ~(|next_status);
    end
  end
endmodule

// *** tb/light_prox_props.sv ***
// checker for the result, threshold and interrupt block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ns
module light_prox_props (
  input logic        clk,
  input logic        srst,
  input logic        scl_in,
  input logic        sda_in,
  input logic        sda_out,
  input logic        sda_oe,
  input logic        int_n,
  input logic [15:0] als_result,
  input logic        als_valid,
  input logic [15:0] prox_result,
  input logic        prox_valid,
  input logic        self_timed_on
);
  // ****************************************
  // bus idle counter and assertions
  // ****************************************
  logic [7:0] idle_cnt;
  always @(posedge clk) begin
    if (srst || !scl_in) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_quiet:
    assert property ($fell(srst) |-> int_n && !sda_oe) else $error("outputs not quiet after reset");
  a_fall_on_valid:
    assert property ($fell(int_n) |-> $past(als_valid) || $past(prox_valid)) else $error("int_n fell without a result");
  a_low_holds:
    assert property ($fell(int_n) |=> !int_n [*2]) else $error("int_n released too soon");
  a_idle_sticky:
    assert property (!int_n && idle_cnt > 8'h28 |=> !int_n) else $error("int_n released with bus idle");
  a_idle_release:
    assert property (idle_cnt > 8'h28 |-> !sda_oe) else $error("data pin driven on idle bus");
  a_oe_scl_low:
    assert property ($changed(sda_oe) |-> !scl_in) else $error("data pin changed while clock high");
  a_open_drain:
    assert property (sda_out == 1'b0) else $error("data pin driven high");
  a_oe_bounded:
    assert property ($rose(sda_oe) |-> ##[1:200] !sda_oe) else $error("data pin held too long");
endmodule
bind light_prox_result_threshold_irq light_prox_props u_light_prox_props (.clk(clk), .srst(srst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_n(int_n),
  .als_result(als_result), .als_valid(als_valid), .prox_result(prox_result),
  .prox_valid(prox_valid), .self_timed_on(self_timed_on));

// *** tb/light_prox_host.sv ***
// host controller model on the two-wire bus
// assumes an open-drain data line with a pull-up outside
`timescale 1ns/1ns
`include "light_prox_defines.vh"
module light_prox_host (
  output logic scl,
  output logic sda_low,
  input  logic sda
);
  // ****************************************
  // bit, byte and transfer tasks
  // ****************************************
  int n_nack;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    n_nack = 0;
  end
  task automatic bit_io(input logic b, output logic r);
    #20 sda_low = !b;
    #60 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack_bit, input logic chk, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_bit, r);
    if (chk && r !== 1'b0) n_nack++;
  endtask
  task automatic start_cond;
    #20 sda_low = 1'b0;
    #60 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop_cond;
    #20 sda_low = 1'b1;
    #60 scl = 1'b1;
    #80 sda_low = 1'b0;
    #400;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start_cond();
    byte_io({`DEVICE_ADDRESS, 1'b0}, 1'b1, 1'b1, q);
    byte_io(a, 1'b1, 1'b1, q);
    byte_io(d, 1'b1, 1'b1, q);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    start_cond();
    byte_io({`DEVICE_ADDRESS, 1'b0}, 1'b1, 1'b1, q);
    byte_io(a, 1'b1, 1'b1, q);
    start_cond();
    byte_io({`DEVICE_ADDRESS, 1'b1}, 1'b1, 1'b1, q);
    byte_io(8'hFF, 1'b1, 1'b0, d);
    stop_cond();
  endtask
endmodule

// *** tb/light_prox_result_threshold_irq_test.sv ***
// self-checking bench for the result, threshold and interrupt block
// assumes the host model drives the bus and the bench drives results
`timescale 1ns/1ns
module light_prox_result_threshold_irq_test;
  logic        clk, srst, scl, host_low, sda, als_valid, prox_valid, self_timed_on;
  logic [15:0] als_result, prox_result;
  wire         sda_out, sda_oe, int_n;
  int          n_fail, n_checks;
  assign sda = !(host_low || (sda_oe && !sda_out));
  light_prox_result_threshold_irq u_light_prox_result_threshold_irq (.clk(clk), .srst(srst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .int_n(int_n),
    .als_result(als_result), .als_valid(als_valid), .prox_result(prox_result),
    .prox_valid(prox_valid), .self_timed_on(self_timed_on));
  light_prox_host u_light_prox_host (.scl(scl), .sda_low(host_low), .sda(sda));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_light_prox_host.read_reg(a, q);
    chk("register", e, q);
  endtask
  task automatic pulse(input logic is_als, input logic [15:0] v);
    @(posedge clk);
    #1 {als_result, prox_result, als_valid, prox_valid} = {v, v, is_als, !is_als};
    @(posedge clk);
    #1 {als_valid, prox_valid} = 2'b00;
  endtask
  task automatic int_is(input logic e);
    chk("int_n", {7'h00, e}, {7'h00, int_n});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int a = 8'h85; a <= 8'h8E; a++) rd(8'(a), 8'h00);
    rd(8'h90, 8'h00);
    int_is(1'b1);
  endtask
  task automatic t_regs;
    logic [7:0] v [4] = '{8'h10, 8'h01, 8'h20, 8'h02};
    for (int i = 0; i < 4; i++) u_light_prox_host.write_reg(8'(8'h8A + i), v[i]);
    for (int i = 0; i < 4; i++) rd(8'(8'h8A + i), v[i]);
  endtask
  task automatic t_results;
    pulse(1'b1, 16'h1234);
    pulse(1'b0, 16'hABCD);
    u_light_prox_host.write_reg(8'h85, 8'hFF);
    u_light_prox_host.write_reg(8'h88, 8'hFF);
    rd(8'h85, 8'h12);
    rd(8'h86, 8'h34);
    rd(8'h87, 8'hAB);
    rd(8'h88, 8'hCD);
    rd(8'h8E, 8'h00);
    int_is(1'b1);
  endtask
  task automatic t_ready;
    u_light_prox_host.write_reg(8'h89, 8'h0C);
    pulse(1'b0, 16'h1800);
    int_is(1'b0);
    rd(8'h8E, 8'h08);
    pulse(1'b1, 16'h1800);
    rd(8'h8E, 8'h0C);
    u_light_prox_host.write_reg(8'h8E, 8'h08);
    rd(8'h8E, 8'h04);
    int_is(1'b0);
    u_light_prox_host.write_reg(8'h8E, 8'h04);
    int_is(1'b1);
  endtask
  task automatic t_count;
    for (int n = 0; n < 8; n++) begin
      u_light_prox_host.write_reg(8'h89, {n[2:0], 5'b00010});
      repeat ((1 << n) - 1) pulse(1'b0, 16'h2003);
      pulse(1'b0, 16'h2002);
      repeat ((1 << n) - 1) pulse(1'b0, 16'h2003);
      rd(8'h8E, 8'h00);
      pulse(1'b0, 16'h2003);
      rd(8'h8E, 8'h01);
      u_light_prox_host.write_reg(8'h8E, 8'h01);
    end
  endtask
  task automatic t_select;
    u_light_prox_host.write_reg(8'h89, 8'h03);
    pulse(1'b0, 16'h1000);
    rd(8'h8E, 8'h00);
    pulse(1'b1, 16'h1000);
    rd(8'h8E, 8'h02);
    u_light_prox_host.write_reg(8'h89, 8'h02);
    u_light_prox_host.write_reg(8'h8E, 8'h02);
    pulse(1'b1, 16'h0000);
    rd(8'h8E, 8'h00);
    pulse(1'b0, 16'h1000);
    rd(8'h8E, 8'h02);
    u_light_prox_host.write_reg(8'h8E, 8'h02);
  endtask
  task automatic t_self_timed;
    u_light_prox_host.write_reg(8'h89, 8'h00);
    @(posedge clk);
    #1 self_timed_on = 1'b1;
    u_light_prox_host.write_reg(8'h89, 8'h08);
    rd(8'h89, 8'h08);
    pulse(1'b0, 16'h1800);
    int_is(1'b1);
    @(posedge clk);
    #1 self_timed_on = 1'b0;
    pulse(1'b0, 16'h1800);
    int_is(1'b0);
    u_light_prox_host.write_reg(8'h8E, 8'h08);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    {n_fail, n_checks} = {32'h0, 32'h0};
    {srst, als_valid, prox_valid, self_timed_on} = 4'b1000;
    {als_result, prox_result} = 32'h0000_0000;
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_results();
    t_ready();
    t_count();
    t_select();
    t_self_timed();
    chk("nack count", 8'h00, u_light_prox_host.n_nack[7:0]);
    complete_run();
  end
endmodule
